// ### rtl/rot_carry_pkg.sv
// Shared constants and carriers for the rotate-through-carry datapath slice
package rot_carry_pkg;
   localparam int INSN_W = 12;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   localparam int NUM_FREGS = 32;
   localparam int OPC_W = 6;
   localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
   localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
   localparam int OPC_LSB = 6;
   localparam int DEST_BIT = 5;
   localparam int FADDR_LSB = 0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] FREG_RESET = 8'ha5;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic DCARRY_RESET = 1'b0;
   localparam int EXEC_CYCLES = 1;

   typedef struct packed {
      logic valid;
      logic [11:0] word;
   } insn_t;

   typedef struct packed {
      logic zero;
      logic dcarry;
      logic carry;
   } status_t;

   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [7:0] data;
   } freg_wr_t;
endpackage

// ### rtl/rotate_through_carry_unit.sv
// Rotate-through-carry execution slice with its own file registers, accumulator and status
`timescale 1ns/1ps
module rotate_through_carry_unit
   import rot_carry_pkg::*;
#(
   parameter int NREGS = rot_carry_pkg::NUM_FREGS
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire rot_carry_pkg::insn_t insn,
   output rot_carry_pkg::status_t status,
   output logic [7:0] acc,
   output rot_carry_pkg::freg_wr_t freg_wr,
   output logic insn_done,
   output logic insn_unknown
);
   import rot_carry_pkg::*;

   // Operand storage
   logic [7:0] fregs [NREGS];

   // Clock enable, freezes every flip-flop while low
   wire advance;

   assign advance = clk_en;

   // Instruction fields
   wire [OPC_W-1:0] opcode;
   wire dest_freg;
   wire [FADDR_W-1:0] faddr;

   assign opcode = insn.word[INSN_W-1:OPC_LSB];
   assign dest_freg = insn.word[DEST_BIT];
   assign faddr = insn.word[FADDR_LSB +: FADDR_W];

   // Decode of the two rotate words
   wire is_right;
   wire is_left;
   wire is_rot;
   wire is_unknown;
   wire wr_acc;
   wire wr_freg;

   assign is_right = insn.valid && (opcode == OPC_ROT_RIGHT);
   assign is_left = insn.valid && (opcode == OPC_ROT_LEFT);
   assign is_rot = is_right || is_left;
   assign is_unknown = insn.valid && !is_rot;
   assign wr_acc = is_rot && !dest_freg;
   assign wr_freg = is_rot && dest_freg;

   // One-hot read select; an index beyond the array reads zero
   wire [NREGS-1:0] rd_sel;
   wire [7:0] rd_word [NREGS];
   logic [7:0] operand;

   genvar ri;
   generate
      for (ri = 0; ri < NREGS; ri++)
      begin : g_rd
         assign rd_sel[ri] = (faddr == FADDR_W'(ri));
         assign rd_word[ri] = rd_sel[ri] ? fregs[ri] : 8'h00;
      end
   endgenerate

   // Masked words ORed into the operand
   always_comb
   begin
      operand = 8'h00;
      for (int k = 0; k < NREGS; k++)
      begin
         operand = operand | rd_word[k];
      end
   end

   // Rotated values, one generate step for each of seven shifted bits, the end bit taken from carry
   wire carry_in;
   wire [7:0] rot_right;
   wire [7:0] rot_left;
   wire [7:0] result;
   wire next_carry;

   assign carry_in = status.carry;
   assign rot_right[7] = carry_in;
   assign rot_left[0] = carry_in;

   genvar bi;
   generate
      for (bi = 0; bi < 7; bi++)
      begin : g_bit
         assign rot_right[bi] = operand[bi+1];
         assign rot_left[bi+1] = operand[bi];
      end
   endgenerate

   assign result = is_right ? rot_right : rot_left;
   assign next_carry = is_right ? operand[0] : operand[7];

   // Next values of the registered outputs
   wire [7:0] next_acc;
   wire next_sc;
   status_t next_status;
   freg_wr_t next_freg_wr;
   wire next_done;
   wire next_unknown;

   assign next_acc = wr_acc ? result : acc;
   assign next_sc = is_rot ? next_carry : status.carry;
   assign next_status = '{zero: status.zero, dcarry: status.dcarry, carry: next_sc};
   assign next_freg_wr = '{wr: wr_freg, addr: faddr, data: result};
   assign next_done = is_rot;
   assign next_unknown = is_unknown;

   // Write select per file register
   wire [NREGS-1:0] freg_sel;

   genvar si;
   generate
      for (si = 0; si < NREGS; si++)
      begin : g_sel
         assign freg_sel[si] = wr_freg && rd_sel[si];
      end
   endgenerate

   // File registers, written back only when the target bit is set
   genvar gi;
   generate
      for (gi = 0; gi < NREGS; gi++)
      begin : g_freg
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               fregs[gi] <= FREG_RESET;
            end
            else if (advance && freg_sel[gi])
            begin
               fregs[gi] <= result;
            end
         end
      end
   endgenerate

   // Accumulator
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         acc <= ACC_RESET;
      end
      else if (advance)
      begin
         acc <= next_acc;
      end
   end

   // Status, only carry moves
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         status <= '{zero: ZERO_RESET, dcarry: DCARRY_RESET, carry: CARRY_RESET};
      end
      else if (advance)
      begin
         status <= next_status;
      end
   end

   // Write-back report
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         freg_wr <= '0;
      end
      else if (advance)
      begin
         freg_wr <= next_freg_wr;
      end
   end

   // Completion strobe, one cycle after decode
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         insn_done <= 1'b0;
      end
      else if (advance)
      begin
         insn_done <= next_done;
      end
   end

   // Strobe for a valid word that is no rotate
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         insn_unknown <= 1'b0;
      end
      else if (advance)
      begin
         insn_unknown <= next_unknown;
      end
   end
endmodule

// ### sim/insn_src.sv
// Fetch and decode stand-in that presents one word each cycle
`timescale 1ns/1ps
module insn_src import rot_carry_pkg::*; (input wire logic [12:0] nxt, output insn_t insn);
assign insn = nxt;
endmodule

// ### sim/rot_chk_properties.sv
// Port checks for the rotate unit
`timescale 1ns/1ps
module rot_chk import rot_carry_pkg::*; (input wire logic clk, arst_n, clk_en,
input wire insn_t insn, input wire status_t status, input wire freg_wr_t freg_wr,
input wire logic insn_done, input wire logic [7:0] acc, input wire logic insn_unknown);
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
wire rot = clk_en && insn.valid && insn.word[11:7] == 5'h06;
AST_DONE: assert property (rot |=> insn_done) else $error("no done");
AST_WB: assert property (rot |=> freg_wr.wr == $past(insn.word[5])) else $error("wb");
AST_ZD: assert property (status[2:1] == 2'h0) else $error("zd");
AST_UNK: assert property ((clk_en && insn.valid && insn.word[11:7] != 5'h06) |=> insn_unknown && !insn_done) else $error("unknown");
AST_FREEZE: assert property (!clk_en |=> $stable(acc) && $stable(status) && $stable(freg_wr)) else $error("freeze");
AST_ACC_KEEP: assert property ((clk_en && !(rot && !insn.word[5])) |=> $stable(acc)) else $error("acc");
AST_CIN_R: assert property ((rot && !insn.word[6] && insn.word[5]) |=> freg_wr.data[7] == $past(status.carry)) else $error("cin right");
AST_CIN_L: assert property ((rot && insn.word[6] && !insn.word[5]) |=> acc[0] == $past(status.carry)) else $error("cin left");
AST_ADDR: assert property ((rot && insn.word[5]) |=> freg_wr.addr == $past(insn.word[4:0])) else $error("addr");
endmodule
bind rotate_through_carry_unit rot_chk chk_u (.*);

// ### sim/rotate_through_carry_unit_tb.sv
// Random self-checking bench for the rotate unit
`timescale 1ns/1ps
module rotate_through_carry_unit_tb;
import rot_carry_pkg::*;
logic clk = 0, arst_n = 0, en = 0, c = 0, ok, done, unk;
logic [13:0] nxt = 0, p;
logic [7:0] acc, a = 0, v, r, m [32];
logic [15:0] f = 0;
insn_t insn;
status_t st;
freg_wr_t fw;
int err_count = 0, n_compared = 0;
always #50 clk = ~clk;
insn_src src_u (.nxt(nxt[12:0]), .insn(insn));
rotate_through_carry_unit dut_u (.clk(clk), .arst_n(arst_n), .clk_en(en), .insn(insn),
   .status(st), .acc(acc), .freg_wr(fw), .insn_done(done), .insn_unknown(unk));
task cmp_state(input logic [15:0] g, e);
begin
   n_compared++;
   if (g !== e)
      err_count++;
   if (g !== e)
      $display("Error at %0t got %h exp %h", $time, g, e);
end
endtask
task cmp_strobe(input logic [15:0] g, e);
begin
   n_compared++;
   if (g !== e)
      err_count++;
   if (g !== e)
      $display("Error at %0t got %h exp %h", $time, g, e);
end
endtask
task report_and_stop;
begin
   $display("compared %0d mismatches %0d", n_compared, err_count);
   if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
   else
      $display("STATUS NOT OK");
   $finish;
end
endtask
initial
begin
   void'($urandom(32'hc54e));
   m = '{default: FREG_RESET};
   repeat (6) @(posedge clk);
   arst_n <= 1;
   for (int i = 0; i < 600; i++)
   begin
      @(posedge clk);
      p = {en, nxt[12:0]};
      ok = p[13] && p[12] && p[11:7] == 5'h06;
      v = m[p[4:0]];
      r = p[6] ? {v[6:0], c} : {c, v[7:1]};
      if (ok)
         c = p[6] ? v[7] : v[0];
      if (ok && p[5])
         m[p[4:0]] = r;
      if (ok && !p[5])
         a = r;
      if (p[13])
         f = {ok, p[12] && !ok, ok & p[5], ok & p[5] ? {p[4:0], r} : 13'h0};
      en <= i < 3 || $urandom % 4 != 0;
      nxt <= i < 3 ? 14'h1325 + 14'(i << 5) :
         {1'b0, $urandom % 8 != 0, $urandom % 4 != 0 ? 5'h06 : 5'($urandom), 7'($urandom)};
      @(negedge clk);
      cmp_state({acc, 5'h0, st}, {a, 5'h0, 2'h0, c});
      cmp_strobe({done, unk, fw.wr, fw.wr ? {fw.addr, fw.data} : 13'h0}, f);
   end
   $display("random rotate run done");
   report_and_stop;
end
endmodule
